// [hdl/sfs_params.svh]
`ifndef SFS_PARAMS_SVH
`define SFS_PARAMS_SVH
`define SFS_CMD_CLRFLAG 8'h50
`define SFS_CMD_PP 8'h02
`define SFS_CMD_DPP 8'hA2
`define SFS_CMD_XDPP 8'hD2
`define SFS_CMD_QPP 8'h32
`define SFS_CMD_XQPP 8'h38
`define SFS_CMD_SSE_A 8'h52
`define SFS_CMD_SSE_B 8'h20
`define SFS_CMD_SE 8'hD8
`define SFS_CMD_BE_A 8'hC7
`define SFS_CMD_BE_B 8'h60
`define SFS_ADDR_W 24
`define SFS_NB_CMD 4'h1
`define SFS_NB_HDR 4'h4
`define SFS_NB_MAX 4'hF
`define SFS_FSR_RESET 8'h80
`define SFS_FSR_READY 8'h80
`define SFS_FSR_SUSP 8'h40
`define SFS_FSR_ERASE 8'h20
`define SFS_FSR_PROG 8'h10
`define SFS_FSR_PROT 8'h02
`define SFS_FSR_ERRS 8'h32
`define SFS_SSE_MASK 24'hFFF000
`define SFS_SE_MASK 24'hFF0000
`define SFS_CLK_MHZ 50
`define SFS_BUF_DEPTH 8
`define SFS_PIN_IDLE 6'h01
`endif

// [hdl/sfs_pkg.sv]
package sfs_pkg;
   typedef enum logic [1:0] {SFS_IDLE = 2'h0, SFS_RUN = 2'h1, SFS_SUSP = 2'h3} sfs_state_type;
   typedef enum logic [1:0] {SFS_LANE_EXT = 2'h0, SFS_LANE_DUAL = 2'h1, SFS_LANE_QUAD = 2'h2}
      sfs_lane_type;
   typedef enum logic [1:0] {SFS_OP_PROG = 2'h0, SFS_OP_SSE = 2'h1, SFS_OP_SE = 2'h2,
      SFS_OP_BE = 2'h3} sfs_op_type;
endpackage

// [hdl/sfs_link_sync.sv]
`timescale 1ns/10ps
`include "sfs_params.svh"
module sfs_link_sync (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   // pins
   input wire logic cs_n_pin,
   input wire logic sclk_pin,
   input wire logic [3:0] dq_pin,
   // sampled view
   output logic cs_high,
   output logic cs_rise,
   output logic sclk_rise,
   output logic [3:0] dq
);
   logic [5:0] meta_q;
   logic [5:0] sync_q;
   logic [1:0] last_q;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= `SFS_PIN_IDLE;
         sync_q <= `SFS_PIN_IDLE;
         last_q <= 2'h1;
      end
      else if (ce)
      begin
         meta_q <= {dq_pin, sclk_pin, cs_n_pin};
         sync_q <= meta_q;
         last_q <= sync_q[1:0];
      end
   end

   // data shares the clock's delay, so it is stable at the detected edge
   assign cs_high = sync_q[0];
   assign cs_rise = sync_q[0] & ~last_q[0];
   assign sclk_rise = sync_q[1] & ~last_q[1];
   assign dq = sync_q[5:2];
endmodule // sfs_link_sync

// [hdl/sfs_fifo.sv]
`timescale 1ns/10ps
module sfs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic flush,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   wire empty = wr_q == rd_q;
   wire push = in_valid && !full;
   wire pop = out_ready && !empty;

   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_q[rd_q[AW-1:0]];

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else if (ce)
      begin
         if (flush)
         begin
            wr_q <= '0;
            rd_q <= '0;
         end
         else
         begin
            if (push)
               wr_q <= wr_q + 1'b1;
            if (pop)
               rd_q <= rd_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (ce && push)
         mem_q[wr_q[AW-1:0]] <= in_data;
   end
endmodule // sfs_fifo

// [hdl/sfs_seq.sv]
// Behaviour
// (R01) clear-flag command clears erase, program, protection errors
// (R02) command lanes: one, two or four
// (R03) host ends clear-flag by raising chip select
// (R04) host sets write enable before program
// (R05) only byte-aligned chip select release executes
// (R06) address bits taken on serial clock rise
// (R07) protected program: no run, latch kept, bits 1,4
// (R08) program timeout clears latch, sets program fail
// (R09) programming only clears bits to zero
// (R10) decode page, dual and quad program codes
// (R11) decode extended dual and quad program codes
// (R12) program: busy while running, latch cleared after
// (R13) execute only on whole-byte clock count
// (R14) erasing sets bits to one
// (R15) erase without write enable ignored silently
// (R16) protected subsector erase: latch kept, bits 1,5
// (R17) erase: controller busy, in-progress set, latch cleared
// (R18) erase completion returns controller flag ready
// (R19) erase timeout clears latch, sets erase error
// (R20) subsector and sector erase fill region ones
// (R21) any address inside region selects it
// (R22) bulk erase refused if any sector locked
// (R23) subsector and sector erase suspend and resume
// (R24) erase self-timed per command after chip select
// (R25) flag bit 4 is program fail or protection
// (R26) write-disable keeps latch after protection error
`timescale 1ns/10ps
`include "sfs_params.svh"
module sfs_seq #(
   parameter int unsigned PP_TIME_US = 100,
   parameter int unsigned SSE_TIME_US = 1000,
   parameter int unsigned SE_TIME_US = 10000,
   parameter int unsigned BE_TIME_US = 100000
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   // link pins
   input wire logic cs_n_pin,
   input wire logic sclk_pin,
   input wire logic [3:0] dq_pin,
   // configuration and side commands
   input wire sfs_pkg::sfs_lane_type lane_mode,
   input wire logic wren_req,
   input wire logic wrdi_req,
   input wire logic suspend_req,
   input wire logic resume_req,
   // protection lookup
   input wire logic prot_hit,
   input wire logic any_locked,
   output logic [`SFS_ADDR_W-1:0] tgt_addr_q,
   // status
   output logic [7:0] fsr_q,
   output logic wel_q,
   output logic wip_q,
   output logic buf_full_q,
   // array side
   input wire logic array_busy,
   input wire logic mem_ready,
   output logic mem_we_q,
   output logic [`SFS_ADDR_W-1:0] mem_addr_q,
   output logic [7:0] mem_clr_q,
   output logic erase_req_q,
   output sfs_pkg::sfs_op_type erase_kind_q,
   output logic [`SFS_ADDR_W-1:0] erase_addr_q,
   output logic erase_hold_q
);
   localparam int unsigned PP_CYC = PP_TIME_US * `SFS_CLK_MHZ;
   localparam int unsigned SSE_CYC = SSE_TIME_US * `SFS_CLK_MHZ;
   localparam int unsigned SE_CYC = SE_TIME_US * `SFS_CLK_MHZ;
   localparam int unsigned BE_CYC = BE_TIME_US * `SFS_CLK_MHZ;

   function automatic logic [2:0] lane_cnt(input sfs_pkg::sfs_lane_type m,
                                           input logic [7:0] c, input logic [3:0] nb);
      lane_cnt = 3'h1;
      if (m == sfs_pkg::SFS_LANE_QUAD)
         lane_cnt = 3'h4;
      else if (m == sfs_pkg::SFS_LANE_DUAL)
         lane_cnt = 3'h2;
      else if (nb != 4'h0)
      begin
         if (c == `SFS_CMD_XDPP || (c == `SFS_CMD_DPP && nb >= `SFS_NB_HDR))
            lane_cnt = 3'h2;
         if (c == `SFS_CMD_XQPP || (c == `SFS_CMD_QPP && nb >= `SFS_NB_HDR))
            lane_cnt = 3'h4;
      end
   endfunction

   function automatic logic [7:0] shift_in(input logic [7:0] s, input logic [3:0] d,
                                           input logic [2:0] n);
      case (n)
         3'h2: shift_in = {s[5:0], d[1:0]};
         3'h4: shift_in = {s[3:0], d[3:0]};
         default: shift_in = {s[6:0], d[0]};
      endcase
   endfunction

   function automatic logic is_prog_code(input logic [7:0] c);
      is_prog_code = c == `SFS_CMD_PP || c == `SFS_CMD_DPP || c == `SFS_CMD_QPP
                  || c == `SFS_CMD_XDPP || c == `SFS_CMD_XQPP;
   endfunction

   // sampled link
   logic cs_high;
   logic cs_rise;
   logic sclk_rise;
   logic [3:0] dq_s;

   sfs_link_sync u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .cs_n_pin(cs_n_pin),
      .sclk_pin(sclk_pin),
      .dq_pin(dq_pin),
      .cs_high(cs_high),
      .cs_rise(cs_rise),
      .sclk_rise(sclk_rise),
      .dq(dq_s)
   );

   // frame state
   logic [2:0] bitc_q;
   logic [3:0] nb_q;
   logic [7:0] sh_q;
   logic [7:0] cmd_q;
   sfs_pkg::sfs_state_type st_q;
   sfs_pkg::sfs_state_type st_d;
   sfs_pkg::sfs_op_type op_q;
   logic [31:0] tmr_q;
   logic [`SFS_ADDR_W-1:0] wa_q;

   wire [2:0] lanes = lane_cnt(lane_mode, cmd_q, nb_q); // [R02] [R11]
   wire [7:0] sh_nx = shift_in(sh_q, dq_s, lanes);
   wire [3:0] bit_sum = {1'b0, bitc_q} + {1'b0, lanes};
   wire take = sclk_rise && !cs_high; // [R06]
   wire byte_done = take && bit_sum[3];
   wire [7:0] cur_cmd = (nb_q == 4'h0) ? sh_nx : cmd_q;

   // command decode
   wire c_clr = cmd_q == `SFS_CMD_CLRFLAG;
   wire c_prog = is_prog_code(cmd_q); // [R10] [R11]
   wire c_sse = cmd_q == `SFS_CMD_SSE_A || cmd_q == `SFS_CMD_SSE_B;
   wire c_se = cmd_q == `SFS_CMD_SE;
   wire c_be = cmd_q == `SFS_CMD_BE_A || cmd_q == `SFS_CMD_BE_B;

   // a release mid-byte is dropped without any flag change
   wire aligned = bitc_q == 3'h0; // [R05] [R13]
   wire idle_ok = cs_rise && aligned && st_q == sfs_pkg::SFS_IDLE;
   wire ex_clr = cs_rise && aligned && c_clr && nb_q >= `SFS_NB_CMD; // [R01] [R03]
   wire try_prog = idle_ok && c_prog && nb_q > `SFS_NB_HDR && wel_q;
   wire try_sec = idle_ok && (c_sse || c_se) && nb_q == `SFS_NB_HDR && wel_q; // [R15]
   wire try_bulk = idle_ok && c_be && nb_q == `SFS_NB_CMD && wel_q; // [R15]
   wire prog_prot = try_prog && prot_hit; // [R07]
   wire era_prot = (try_sec && prot_hit) || (try_bulk && any_locked); // [R16] [R22]
   wire start_prog = try_prog && !prot_hit;
   wire start_era = (try_sec && !prot_hit) || (try_bulk && !any_locked);
   wire running = st_q == sfs_pkg::SFS_RUN;
   wire op_end = running && tmr_q == 32'h0;
   wire can_susp = op_q == sfs_pkg::SFS_OP_SSE || op_q == sfs_pkg::SFS_OP_SE;

   // page buffer
   logic buf_in_ready;
   logic buf_out_valid;
   logic [7:0] buf_out_data;
   wire push = byte_done && is_prog_code(cur_cmd) && nb_q >= `SFS_NB_HDR
            && st_q == sfs_pkg::SFS_IDLE;
   wire flush = (cs_rise && !start_prog) || op_end;
   wire drain = running && op_q == sfs_pkg::SFS_OP_PROG;
   wire pop = drain && buf_out_valid && (!mem_we_q || mem_ready);

   // bytes past the buffer depth are lost; buf_full_q tells the controller
   sfs_fifo #(
      .WIDTH(8),
      .DEPTH(`SFS_BUF_DEPTH)
   ) u_buf (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .flush(flush),
      .in_valid(push),
      .in_ready(buf_in_ready),
      .in_data(sh_nx),
      .out_valid(buf_out_valid),
      .out_ready(pop),
      .out_data(buf_out_data)
   );

   // array failed to finish inside the self-timed window
   wire fault = array_busy || (op_q == sfs_pkg::SFS_OP_PROG && (buf_out_valid || mem_we_q));
   wire [7:0] end_err = (op_q == sfs_pkg::SFS_OP_PROG) ? `SFS_FSR_PROG : `SFS_FSR_ERASE;
   wire [7:0] err_set = (prog_prot ? (`SFS_FSR_PROT | `SFS_FSR_PROG) : 8'h00) // [R07] [R25]
                      | (era_prot ? (`SFS_FSR_PROT | `SFS_FSR_ERASE) : 8'h00) // [R16] [R22]
                      | ((op_end && fault) ? end_err : 8'h00); // [R08] [R19]
   wire [7:0] err_clr = ex_clr ? `SFS_FSR_ERRS : 8'h00; // [R01]
   wire [7:0] err_d = (fsr_q & `SFS_FSR_ERRS & ~err_clr) | err_set;
   wire [7:0] ctl_d = (st_d == sfs_pkg::SFS_RUN) ? 8'h00 : `SFS_FSR_READY; // [R17] [R18]
   wire [7:0] fsr_d = err_d | ctl_d | ((st_d == sfs_pkg::SFS_SUSP) ? `SFS_FSR_SUSP : 8'h00);
   wire keep_wel = (fsr_q & `SFS_FSR_PROT) != 8'h00;
   wire op_kind_sel = start_era && try_bulk;

   always_comb
   begin
      st_d = st_q;
      case (st_q)
         sfs_pkg::SFS_IDLE:
            if (start_prog || start_era)
               st_d = sfs_pkg::SFS_RUN;
         sfs_pkg::SFS_RUN:
            if (op_end)
               st_d = sfs_pkg::SFS_IDLE;
            else if (suspend_req && can_susp)
               st_d = sfs_pkg::SFS_SUSP; // [R23]
         sfs_pkg::SFS_SUSP:
            if (resume_req)
               st_d = sfs_pkg::SFS_RUN; // [R23]
         default:
            st_d = sfs_pkg::SFS_IDLE;
      endcase
   end

   // serial framing
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bitc_q <= 3'h0;
         nb_q <= 4'h0;
         sh_q <= 8'h00;
         cmd_q <= 8'h00;
         tgt_addr_q <= '0;
      end
      else if (ce)
      begin
         if (cs_high)
         begin
            bitc_q <= 3'h0;
            nb_q <= 4'h0;
         end
         else if (take)
         begin
            bitc_q <= bit_sum[2:0];
            sh_q <= sh_nx;
            if (byte_done && nb_q != `SFS_NB_MAX)
               nb_q <= nb_q + 4'h1;
            if (byte_done && nb_q == 4'h0)
               cmd_q <= sh_nx;
            if (byte_done && nb_q != 4'h0 && nb_q < `SFS_NB_HDR)
               tgt_addr_q <= {tgt_addr_q[`SFS_ADDR_W-9:0], sh_nx}; // [R06]
         end
      end
   end

   // operation control
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= sfs_pkg::SFS_IDLE;
         op_q <= sfs_pkg::SFS_OP_PROG;
         tmr_q <= 32'h0;
         fsr_q <= `SFS_FSR_RESET;
         wip_q <= 1'b0;
         erase_hold_q <= 1'b0;
      end
      else if (ce)
      begin
         st_q <= st_d;
         fsr_q <= fsr_d;
         wip_q <= st_d == sfs_pkg::SFS_RUN; // [R12] [R17]
         erase_hold_q <= st_d == sfs_pkg::SFS_SUSP;
         if (start_prog)
         begin
            op_q <= sfs_pkg::SFS_OP_PROG;
            tmr_q <= PP_CYC;
         end
         else if (start_era) // [R24]
         begin
            op_q <= op_kind_sel ? sfs_pkg::SFS_OP_BE
                  : (c_se ? sfs_pkg::SFS_OP_SE : sfs_pkg::SFS_OP_SSE);
            tmr_q <= op_kind_sel ? BE_CYC : (c_se ? SE_CYC : SSE_CYC);
         end
         else if (running && tmr_q != 32'h0)
            tmr_q <= tmr_q - 32'h1;
      end
   end

   // write enable latch
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         wel_q <= 1'b0;
      else if (ce)
      begin
         if (op_end || ex_clr) // [R08] [R12] [R17] [R19] [R26]
            wel_q <= 1'b0;
         else if (wren_req)
            wel_q <= 1'b1;
         else if (wrdi_req && !keep_wel) // [R26]
            wel_q <= 1'b0;
      end
   end

   // array write and erase requests
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_we_q <= 1'b0;
         mem_addr_q <= '0;
         mem_clr_q <= 8'h00;
         wa_q <= '0;
         erase_req_q <= 1'b0;
         erase_kind_q <= sfs_pkg::SFS_OP_SSE;
         erase_addr_q <= '0;
         buf_full_q <= 1'b0;
      end
      else if (ce)
      begin
         buf_full_q <= !buf_in_ready;
         erase_req_q <= start_era; // [R14] [R20]
         if (start_era)
         begin
            erase_kind_q <= op_kind_sel ? sfs_pkg::SFS_OP_BE
                          : (c_se ? sfs_pkg::SFS_OP_SE : sfs_pkg::SFS_OP_SSE);
            erase_addr_q <= op_kind_sel ? '0 : (tgt_addr_q &
                            (c_se ? `SFS_SE_MASK : `SFS_SSE_MASK)); // [R21]
         end
         if (start_prog)
            wa_q <= tgt_addr_q;
         if (pop)
         begin
            mem_we_q <= 1'b1;
            mem_addr_q <= wa_q;
            mem_clr_q <= ~buf_out_data; // [R09]
            wa_q <= wa_q + `SFS_ADDR_W'(1);
         end
         else if (mem_ready)
            mem_we_q <= 1'b0;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n || !ce);

   chk_clear_errs: assert property (ex_clr && !op_end |=> (fsr_q & `SFS_FSR_ERRS) == 8'h00) // [R01]
      else $error("clear-flag left an error bit set");
   chk_prog_prot: assert property (prog_prot |=> fsr_q[1] && fsr_q[4] && wel_q
                                  && st_q == sfs_pkg::SFS_IDLE) // [R07]
      else $error("protected program not refused correctly");
   chk_erase_prot: assert property (era_prot |=> fsr_q[1] && fsr_q[5] && wel_q && !wip_q) // [R16]
      else $error("protected erase not refused correctly");
   chk_busy_flags: assert property (running |-> wip_q && !fsr_q[7]) // [R12]
      else $error("busy flags wrong during operation");
   chk_end_release: assert property (op_end |=> !wip_q && !wel_q && fsr_q[7]) // [R17]
      else $error("operation end did not release flags");
   chk_misalign_drop: assert property (cs_rise && !aligned && !ex_clr
                                      |=> $stable(fsr_q) && st_q == $past(st_q)) // [R13]
      else $error("misaligned frame had an effect");
   chk_erase_nowel: assert property (cs_rise && (c_sse || c_se || c_be) && !wel_q
                                    |=> st_q == sfs_pkg::SFS_IDLE && $stable(fsr_q)) // [R15]
      else $error("erase without latch not ignored");
   chk_timeout_flag: assert property (op_end && fault && op_q == sfs_pkg::SFS_OP_PROG
                                     |=> fsr_q[4] && !wel_q) // [R08]
      else $error("program timeout not flagged");
   chk_erase_tmo: assert property (op_end && array_busy && op_q != sfs_pkg::SFS_OP_PROG
                                  |=> fsr_q[5]) // [R19]
      else $error("erase timeout not flagged");
   chk_prog_clear: assert property (pop |=> mem_we_q && mem_clr_q == ~$past(buf_out_data)) // [R09]
      else $error("program write mask wrong");
   chk_erase_start: assert property (start_era |=> erase_req_q ##1 !erase_req_q) // [R24]
      else $error("erase request not a single pulse");

   cov_program: cover property (start_prog ##[1:1000] op_end);
   cov_erase: cover property (start_era);
   cov_suspend: cover property (st_q == sfs_pkg::SFS_SUSP ##[1:300] st_q == sfs_pkg::SFS_RUN);
endmodule // sfs_seq

// [testbench/sfs_host_model.sv]
`timescale 1ns/10ps
module sfs_host_model (
   // clock
   input wire logic clk_sys,
   // link pins
   output logic cs_n_pin,
   output logic sclk_pin,
   output logic [3:0] dq_pin
);
   initial
   begin
      cs_n_pin = 1'b1;
      sclk_pin = 1'b0;
      dq_pin = 4'h5;
   end
   // half a serial clock period, 80 ns
   task automatic half();
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic tick(input int w, input logic [3:0] v);
      // idle lanes toggle so no stale level can be taken for data
      dq_pin <= (w == 4) ? v : (w == 2) ? {~dq_pin[3:2], v[3:2]} : {~dq_pin[3:1], v[3]};
      sclk_pin <= 1'b0;
      half();
      sclk_pin <= 1'b1;
      half();
   endtask
   // lanes for command, address and data bytes; xb stray bits make a partial byte
   task automatic frame(input logic [7:0] b [16], input int n, input int wc, input int wa,
      input int wd, input int xb);
      int w;
      logic [7:0] s;
      cs_n_pin <= 1'b0;
      half();
      for (int i = 0; i < n; i++)
      begin
         w = (i == 0) ? wc : (i < 4) ? wa : wd;
         s = b[i];
         for (int k = 0; k < 8 / w; k++)
         begin
            tick(w, s[7:4]);
            s = s << w;
         end
      end
      for (int k = 0; k < xb; k++)
         tick(1, 4'hF);
      sclk_pin <= 1'b0;
      dq_pin <= ~dq_pin;
      half();
      cs_n_pin <= 1'b1;
      half();
   endtask
endmodule // sfs_host_model

// [testbench/sfs_seq_tb.sv]
`timescale 1ns/10ps
module sfs_seq_tb;
   localparam int PP_CYC = 50;
   localparam int SSE_CYC = 100;
   localparam int SE_CYC = 150;
   localparam int BE_CYC = 200;
   localparam logic [23:0] ADDR = 24'h123456;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic cs_n_pin, sclk_pin;
   logic [3:0] dq_pin;
   sfs_pkg::sfs_lane_type lane_mode = sfs_pkg::SFS_LANE_EXT;
   logic wren_req = 1'b0, wrdi_req = 1'b0, suspend_req = 1'b0, resume_req = 1'b0;
   logic prot_hit = 1'b0, any_locked = 1'b0, array_busy = 1'b0, mem_ready = 1'b0;
   logic [23:0] tgt_addr_q, mem_addr_q, erase_addr_q, er_addr;
   logic [7:0] fsr_q, mem_clr_q;
   logic wel_q, wip_q, buf_full_q, mem_we_q, erase_req_q, erase_hold_q;
   sfs_pkg::sfs_op_type erase_kind_q, er_kind;
   logic [23:0] cap_a [$];
   logic [7:0] cap_c [$];
   int er_cnt = 0;
   logic full_seen = 1'b0;
   int fails = 0;
   int num_checks = 0;
   always #10 clk_sys = ~clk_sys;
   sfs_seq #(.PP_TIME_US(1), .SSE_TIME_US(2), .SE_TIME_US(3), .BE_TIME_US(4)) sfs_seq_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
      .dq_pin(dq_pin), .lane_mode(lane_mode), .wren_req(wren_req), .wrdi_req(wrdi_req),
      .suspend_req(suspend_req), .resume_req(resume_req), .prot_hit(prot_hit),
      .any_locked(any_locked), .tgt_addr_q(tgt_addr_q), .fsr_q(fsr_q), .wel_q(wel_q),
      .wip_q(wip_q), .buf_full_q(buf_full_q), .array_busy(array_busy), .mem_ready(mem_ready),
      .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_clr_q(mem_clr_q),
      .erase_req_q(erase_req_q), .erase_kind_q(erase_kind_q), .erase_addr_q(erase_addr_q),
      .erase_hold_q(erase_hold_q));
   sfs_host_model sfs_host_model_inst (.clk_sys(clk_sys), .cs_n_pin(cs_n_pin),
      .sclk_pin(sclk_pin), .dq_pin(dq_pin));
   always @(posedge clk_sys)
   begin
      // array stalls every other cycle
      mem_ready <= ~mem_ready;
      if (mem_we_q === 1'b1 && mem_ready === 1'b1)
      begin
         cap_a.push_back(mem_addr_q);
         cap_c.push_back(mem_clr_q);
      end
      if (erase_req_q === 1'b1)
      begin
         er_cnt++;
         er_kind = erase_kind_q;
         er_addr = erase_addr_q;
      end
      if (buf_full_q === 1'b1)
         full_seen = 1'b1;
   end
   task automatic stop_test();
      if (fails == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'b1)
      begin
         fails++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // 0 write enable, 1 write disable, 2 suspend, 3 resume
   task automatic pulse(input int k);
      @(posedge clk_sys);
      {resume_req, suspend_req, wrdi_req, wren_req} <= 4'h1 << k;
      @(posedge clk_sys);
      {resume_req, suspend_req, wrdi_req, wren_req} <= 4'h0;
   endtask
   task automatic send(input logic [7:0] cmd, input int n, input int wc, input int wa,
      input int wd, input int xb);
      logic [7:0] fb [16];
      fb[0] = cmd;
      {fb[1], fb[2], fb[3]} = ADDR;
      for (int i = 4; i < 16; i++)
         fb[i] = 8'hA5 ^ 8'(i * 17);
      sfs_host_model_inst.frame(fb, n, wc, wa, wd, xb);
   endtask
   task automatic wait_wip(input logic v, input int lim);
      for (int i = 0; i < lim && wip_q !== v; i++)
         @(posedge clk_sys);
      chk(wip_q === v, "write in progress flag");
   endtask
   task automatic clear(input sfs_pkg::sfs_lane_type m, input int w);
      @(posedge clk_sys);
      lane_mode <= m;
      send(8'h50, 1, w, w, w, 0);
      cyc(4);
      chk(fsr_q === 8'h80 && wel_q === 1'b0, "flags not cleared");
      lane_mode <= sfs_pkg::SFS_LANE_EXT;
   endtask
   task automatic t_reset();
      chk(fsr_q === 8'h80 && wel_q === 1'b0 && wip_q === 1'b0, "reset state");
      chk(erase_hold_q === 1'b0 && erase_req_q === 1'b0 && mem_we_q === 1'b0, "reset outputs");
   endtask
   // nine data bytes: one more than the page buffer holds
   task automatic t_prog(input logic [7:0] cmd, input int wc, input int wa, input int wd);
      logic [7:0] d;
      pulse(0);
      cap_a.delete();
      cap_c.delete();
      full_seen = 1'b0;
      send(cmd, 13, wc, wa, wd, 0);
      wait_wip(1'b1, 10);
      chk(fsr_q[7] === 1'b0, "ready flag during program");
      wait_wip(1'b0, PP_CYC + 20);
      chk(wel_q === 1'b0 && fsr_q === 8'h80, "program end state");
      chk(full_seen === 1'b1 && cap_a.size() == 8, "page buffer byte count");
      for (int i = 0; i < cap_a.size(); i++)
      begin
         d = 8'hA5 ^ 8'(i * 17 + 68);
         chk(cap_a[i] === ADDR + 24'(i), "program address");
         chk(cap_c[i] === ~d, "program clear mask");
      end
   endtask
   task automatic t_partial();
      pulse(0);
      send(8'h02, 5, 1, 1, 1, 3);
      cyc(10);
      chk(wip_q === 1'b0 && fsr_q === 8'h80 && wel_q === 1'b1, "partial byte ran");
   endtask
   // latch still set from the partial frame
   task automatic t_prot();
      @(posedge clk_sys);
      prot_hit <= 1'b1;
      send(8'h02, 6, 1, 1, 1, 0);
      cyc(4);
      chk(fsr_q === 8'h92 && wel_q === 1'b1 && wip_q === 1'b0, "protected program");
      chk(tgt_addr_q === ADDR, "target address");
      pulse(1);
      cyc(2);
      chk(wel_q === 1'b1, "latch lost on write disable");
      prot_hit <= 1'b0;
      clear(sfs_pkg::SFS_LANE_QUAD, 4);
   endtask
   task automatic t_erase(input logic [7:0] cmd, input int n, input sfs_pkg::sfs_op_type k,
      input logic [23:0] a, input int dur);
      pulse(0);
      er_cnt = 0;
      send(cmd, n, 1, 1, 1, 0);
      wait_wip(1'b1, 10);
      chk(fsr_q === 8'h00, "controller flag during erase");
      cyc(2);
      chk(er_cnt == 1 && er_kind === k && er_addr === a, "erase request");
      cyc(dur - 12);
      chk(wip_q === 1'b1, "erase ended early");
      wait_wip(1'b0, 30);
      chk(fsr_q === 8'h80 && wel_q === 1'b0, "erase end state");
   endtask
   task automatic t_erase_nowel();
      er_cnt = 0;
      send(8'h20, 4, 1, 1, 1, 0);
      cyc(10);
      chk(er_cnt == 0 && wip_q === 1'b0 && fsr_q === 8'h80, "erase without latch");
   endtask
   task automatic t_faults();
      @(posedge clk_sys);
      prot_hit <= 1'b1;
      pulse(0);
      send(8'h20, 4, 1, 1, 1, 0);
      cyc(4);
      chk(fsr_q === 8'hA2 && wel_q === 1'b1 && wip_q === 1'b0, "protected erase");
      clear(sfs_pkg::SFS_LANE_DUAL, 2);
      prot_hit <= 1'b0;
      any_locked <= 1'b1;
      pulse(0);
      send(8'hC7, 1, 1, 1, 1, 0);
      cyc(4);
      chk(fsr_q === 8'hA2 && wel_q === 1'b1, "locked bulk erase");
      clear(sfs_pkg::SFS_LANE_EXT, 1);
      any_locked <= 1'b0;
      array_busy <= 1'b1;
      pulse(0);
      send(8'h20, 4, 1, 1, 1, 0);
      wait_wip(1'b1, 10);
      wait_wip(1'b0, SSE_CYC + 20);
      chk(fsr_q === 8'hA0 && wel_q === 1'b0, "erase timeout");
      pulse(0);
      send(8'h02, 6, 1, 1, 1, 0);
      wait_wip(1'b1, 10);
      wait_wip(1'b0, PP_CYC + 20);
      chk(fsr_q === 8'hB0 && wel_q === 1'b0, "program timeout");
      clear(sfs_pkg::SFS_LANE_EXT, 1);
      array_busy <= 1'b0;
   endtask
   task automatic t_suspend();
      pulse(0);
      send(8'hD8, 4, 1, 1, 1, 0);
      wait_wip(1'b1, 10);
      // a timer running through the freeze would end the erase before the suspend
      ce <= 1'b0;
      cyc(SE_CYC);
      chk(wip_q === 1'b1 && fsr_q === 8'h00, "clock enable freeze");
      ce <= 1'b1;
      cyc(20);
      pulse(2);
      cyc(3);
      chk(erase_hold_q === 1'b1 && fsr_q === 8'hC0 && wip_q === 1'b0, "erase suspend");
      cyc(SE_CYC);
      chk(erase_hold_q === 1'b1, "suspend not held");
      pulse(3);
      cyc(3);
      chk(erase_hold_q === 1'b0 && fsr_q === 8'h00 && wip_q === 1'b1, "erase resume");
      wait_wip(1'b0, SE_CYC);
      chk(fsr_q === 8'h80, "resumed erase end");
   endtask
   initial
   begin
      cyc(10);
      rst_n <= 1'b1;
      cyc(4);
      t_reset();
      t_prog(8'h02, 1, 1, 1);
      t_prog(8'hA2, 1, 1, 2);
      t_prog(8'hD2, 1, 2, 2);
      t_prog(8'h32, 1, 1, 4);
      t_prog(8'h38, 1, 4, 4);
      lane_mode <= sfs_pkg::SFS_LANE_DUAL;
      t_prog(8'h02, 2, 2, 2);
      lane_mode <= sfs_pkg::SFS_LANE_EXT;
      t_partial();
      t_prot();
      t_erase_nowel();
      t_erase(8'h52, 4, sfs_pkg::SFS_OP_SSE, 24'h123000, SSE_CYC);
      t_erase(8'h20, 4, sfs_pkg::SFS_OP_SSE, 24'h123000, SSE_CYC);
      t_erase(8'hD8, 4, sfs_pkg::SFS_OP_SE, 24'h120000, SE_CYC);
      t_erase(8'hC7, 1, sfs_pkg::SFS_OP_BE, 24'h000000, BE_CYC);
      t_erase(8'h60, 1, sfs_pkg::SFS_OP_BE, 24'h000000, BE_CYC);
      t_faults();
      t_suspend();
      stop_test();
   end
   // whole run is near 8200 cycles
   initial
   begin
      cyc(40000);
      fails++;
      stop_test();
   end
endmodule // sfs_seq_tb
